// ===== hw/scpf_core.sv
// serial control port: framing, bit order, address stepping and the head registers
// assumes sclk, select and data pins are asynchronous and slow against clock
// (at least four clock periods per sclk phase); the pad merges out and oe_n.
`timescale 1ns/10ps
`include "scpf_params.svh"
module scpf_core
    import scpf_pkg::*;
#(
    parameter logic [7:0] IDENT_LOW  = 8'h5a, // arbitrary value
    parameter logic [7:0] IDENT_HIGH = 8'hc3, // arbitrary value
    parameter int         FIFO_DEPTH = 8
) (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       sclk_pin,
    input  wire logic       select_n_pin,
    input  wire logic       sdio_in,
    output logic            sdio_out,
    output logic            sdio_oe_n,
    output logic            separate_read_output,
    output logic            separate_read_output_oe_n,
    input  wire logic       update_pin,
    output logic      [7:0] power_down_and_enable,
    output logic            lsb_first_active,
    output logic            write_overrun
);
    localparam int FW = `SCPF_ADDR_W + 8;

    // pin synchronisers
    logic sclk_meta, sclk_sync, sclk_prev;
    logic sel_meta, select_n_sync;
    logic sdio_meta, sdio_sync;
    logic upd_meta, upd_sync, upd_prev;
    logic sclk_rise, sclk_fall, upd_rise;

    // serial framing
    scpf_state_t state;
    logic [3:0]  bit_cnt;
    logic [15:0] shift;
    logic [15:0] next_shift;
    scpf_byte_t  rx_byte;
    logic        xfer_lsb;
    logic        is_read;
    logic        stream;
    logic [1:0]  bytes_left;
    scpf_addr_t  cur_addr;
    scpf_addr_t  next_addr;
    scpf_addr_t  instr_addr;
    scpf_byte_t  out_shift;
    logic        out_bit;
    logic        drive_en;

    // write path
    logic          push_valid;
    logic [FW-1:0] push_data;
    logic          push_ready;
    logic          drain_valid;
    logic          drain_ready;
    logic [FW-1:0] drain_data;
    scpf_addr_t    wr_addr;
    scpf_byte_t    wr_data;

    // registers
    scpf_byte_t cfg_buf;
    scpf_byte_t cfg_act;
    scpf_byte_t options;
    scpf_byte_t pd_buf;
    logic       commit_req;
    logic       commit_now;
    logic       soft_rst;
    logic       core_rst;

    function automatic scpf_byte_t mirror(input scpf_byte_t d);
        scpf_byte_t r;
        for (int i = 0; i < 8; i++) begin
            r[i] = d[7-i];
        end
        return d | r;
    endfunction

    function automatic scpf_byte_t read_reg(input scpf_addr_t a, input scpf_byte_t cb,
                                            input scpf_byte_t ca, input scpf_byte_t op,
                                            input scpf_byte_t pb, input scpf_byte_t pa);
        logic rb;
        rb = op[`SCPF_OPT_RDBUF_BIT];
        case (a)
            `SCPF_ADDR_CFG:     return rb ? cb : ca;
            `SCPF_ADDR_ID_LOW:  return IDENT_LOW;
            `SCPF_ADDR_ID_HIGH: return IDENT_HIGH;
            `SCPF_ADDR_OPT:     return op;
            `SCPF_ADDR_PD:      return rb ? pb : pa;
            default:            return 8'h00;
        endcase
    endfunction

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sclk_meta     <= 1'b0;
            sclk_sync     <= 1'b0;
            sclk_prev     <= 1'b0;
            sel_meta      <= 1'b1;
            select_n_sync <= 1'b1;
            sdio_meta     <= 1'b0;
            sdio_sync     <= 1'b0;
            upd_meta      <= 1'b0;
            upd_sync      <= 1'b0;
            upd_prev      <= 1'b0;
        end else begin
            sclk_meta     <= sclk_pin;
            sclk_sync     <= sclk_meta;
            sclk_prev     <= sclk_sync;
            sel_meta      <= select_n_pin;
            select_n_sync <= sel_meta;
            sdio_meta     <= sdio_in;
            sdio_sync     <= sdio_meta;
            upd_meta      <= update_pin;
            upd_sync      <= upd_meta;
            upd_prev      <= upd_sync;
        end
    end

    assign sclk_rise = sclk_sync && !sclk_prev;
    assign sclk_fall = !sclk_sync && sclk_prev;
    assign upd_rise  = upd_sync && !upd_prev;
    assign core_rst  = sys_rst || soft_rst;

    // both orders end with the whole word aligned after 16 shifts
    assign next_shift = xfer_lsb ? {sdio_sync, shift[15:1]}
                                 : {shift[14:0], sdio_sync};
    assign rx_byte    = xfer_lsb ? next_shift[15:8] : next_shift[7:0];
    assign instr_addr = next_shift[`SCPF_ADDR_W-1:0];
    // 13-bit wrap at either end, no address is ever skipped
    assign next_addr  = xfer_lsb ? cur_addr + 13'h0001
                                 : cur_addr - 13'h0001;

    // bit order is frozen while selected, picked up while deselected (also across a stall) and before the first instruction bit
    always_ff @(posedge clock) begin
        if (core_rst) begin
            xfer_lsb <= 1'b0;
        end else if (select_n_sync || (state == scpf_instr && bit_cnt == 4'h0)) begin
            xfer_lsb <= cfg_act[`SCPF_CFG_LSB_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (core_rst) begin
            state      <= scpf_instr;
            bit_cnt    <= 4'h0;
            shift      <= 16'h0000;
            is_read    <= 1'b0;
            stream     <= 1'b0;
            bytes_left <= 2'h0;
            cur_addr   <= 13'h0000;
            push_valid <= 1'b0;
            push_data  <= '0;
        end else begin
            push_valid <= 1'b0;
            if (select_n_sync) begin
                // a stall is only legal on a byte boundary of a counted frame
                if (bit_cnt[2:0] != 3'h0 || stream || state == scpf_done) begin
                    state   <= scpf_instr;
                    bit_cnt <= 4'h0;
                    stream  <= 1'b0;
                end
            end else if (sclk_rise && state != scpf_done) begin
                shift   <= next_shift;
                bit_cnt <= bit_cnt + 4'h1;
                if (state == scpf_instr && bit_cnt == `SCPF_INSTR_LAST) begin
                    is_read  <= next_shift[`SCPF_INSTR_RW_BIT];
                    stream   <= next_shift[`SCPF_INSTR_LEN_HI:`SCPF_INSTR_LEN_LO]
                                == `SCPF_LEN_STREAM;
                    bytes_left <= next_shift[`SCPF_INSTR_LEN_HI:`SCPF_INSTR_LEN_LO]
                                  + 2'h1;
                    cur_addr <= instr_addr;
                    state    <= scpf_data;
                    bit_cnt  <= 4'h0;
                end else if (state == scpf_data && bit_cnt[2:0] == `SCPF_BYTE_LAST) begin
                    bit_cnt  <= 4'h0;
                    cur_addr <= next_addr;
                    if (!is_read) begin
                        push_valid <= 1'b1;
                        push_data  <= {cur_addr, rx_byte};
                    end
                    if (!stream) begin
                        bytes_left <= bytes_left - 2'h1;
                        if (bytes_left == 2'h1) begin
                            state <= scpf_done;
                        end
                    end
                end
            end
        end
    end

    // read shifter: loaded when a byte boundary passes, shifted on falling edges
    always_ff @(posedge clock) begin
        if (core_rst) begin
            out_shift <= 8'h00;
            out_bit   <= 1'b0;
        end else if (!select_n_sync && sclk_rise) begin
            if (state == scpf_instr && bit_cnt == `SCPF_INSTR_LAST) begin
                out_shift <= read_reg(instr_addr, cfg_buf, cfg_act, options,
                                      pd_buf, power_down_and_enable);
            end else if (state == scpf_data && bit_cnt[2:0] == `SCPF_BYTE_LAST) begin
                out_shift <= read_reg(next_addr, cfg_buf, cfg_act, options,
                                      pd_buf, power_down_and_enable);
            end
        end else if (!select_n_sync && sclk_fall && state == scpf_data && is_read) begin
            out_bit   <= xfer_lsb ? out_shift[0] : out_shift[7];
            out_shift <= xfer_lsb ? {1'b0, out_shift[7:1]} : {out_shift[6:0], 1'b0};
        end
    end

    assign drive_en = !select_n_sync && is_read && state == scpf_data;

    always_ff @(posedge clock) begin
        if (core_rst) begin
            sdio_out                  <= 1'b0;
            separate_read_output      <= 1'b0;
            sdio_oe_n                 <= 1'b1;
            separate_read_output_oe_n <= 1'b1;
        end else begin
            sdio_out                  <= out_bit;
            separate_read_output      <= out_bit;
            sdio_oe_n                 <= !(drive_en && !cfg_act[`SCPF_CFG_SDO_BIT]);
            separate_read_output_oe_n <= !(drive_en && cfg_act[`SCPF_CFG_SDO_BIT]);
        end
    end

    // decouples the serial side from register writes; drain stalls on commits
    scpf_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .clock     (clock),
        .sys_rst   (core_rst),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (drain_valid),
        .out_ready (drain_ready),
        .out_data  (drain_data)
    );

    assign commit_now  = commit_req || upd_rise;
    assign drain_ready = !commit_now;
    assign wr_addr     = drain_data[FW-1:8];
    assign wr_data     = drain_data[7:0];

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            write_overrun <= 1'b0;
        end else if (push_valid && !push_ready) begin
            write_overrun <= 1'b1;
        end
    end

    // lsb pair only takes effect on commit; the other pairs are live
    always_ff @(posedge clock) begin
        if (core_rst) begin
            cfg_buf               <= `SCPF_CFG_RESET;
            cfg_act               <= `SCPF_CFG_RESET;
            options               <= `SCPF_OPT_RESET;
            pd_buf                <= `SCPF_PD_RESET;
            power_down_and_enable <= `SCPF_PD_RESET;
            commit_req            <= 1'b0;
            soft_rst              <= 1'b0;
        end else begin
            if (commit_now) begin
                commit_req <= 1'b0;
                cfg_act    <= (cfg_act & ~`SCPF_CFG_LSB_MASK)
                              | (cfg_buf & `SCPF_CFG_LSB_MASK);
                power_down_and_enable <= pd_buf;
            end else if (drain_valid) begin
                case (wr_addr)
                    `SCPF_ADDR_CFG: begin
                        cfg_buf  <= mirror(wr_data);
                        cfg_act  <= (mirror(wr_data) & ~`SCPF_CFG_LSB_MASK)
                                    | (cfg_act & `SCPF_CFG_LSB_MASK);
                        soft_rst <= wr_data[`SCPF_CFG_SRST_BIT] | wr_data[7-`SCPF_CFG_SRST_BIT];
                    end
                    `SCPF_ADDR_OPT: begin
                        options <= wr_data & `SCPF_OPT_MASK;
                    end
                    `SCPF_ADDR_UPD: begin
                        commit_req <= wr_data[`SCPF_UPD_BIT];
                    end
                    `SCPF_ADDR_PD: begin
                        pd_buf <= wr_data;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (core_rst) begin
            lsb_first_active <= 1'b0;
        end else begin
            lsb_first_active <= cfg_act[`SCPF_CFG_LSB_BIT];
        end
    end
endmodule

// ===== include/scpf_params.svh
// offsets, field positions, reset values and frame sizes of the serial control port
// assumes byte-wide registers on a 13-bit address space
`ifndef SCPF_PARAMS_SVH
`define SCPF_PARAMS_SVH

`define SCPF_ADDR_W          13
`define SCPF_INSTR_LAST      4'hf
`define SCPF_BYTE_LAST       3'h7
`define SCPF_INSTR_RW_BIT    15
`define SCPF_INSTR_LEN_HI    14
`define SCPF_INSTR_LEN_LO    13
`define SCPF_LEN_STREAM      2'h3

`define SCPF_ADDR_CFG        13'h0000
`define SCPF_ADDR_ID_LOW     13'h0002
`define SCPF_ADDR_ID_HIGH    13'h0003
`define SCPF_ADDR_OPT        13'h0004
`define SCPF_ADDR_UPD        13'h0005
`define SCPF_ADDR_PD         13'h0010

`define SCPF_CFG_RESET       8'h18
`define SCPF_OPT_RESET       8'h00
`define SCPF_PD_RESET        8'h00

`define SCPF_CFG_SDO_BIT     7
`define SCPF_CFG_LSB_BIT     6
`define SCPF_CFG_SRST_BIT    5
`define SCPF_CFG_LSB_MASK    8'h42
`define SCPF_OPT_RDBUF_BIT   0
`define SCPF_OPT_MASK        8'h01
`define SCPF_UPD_BIT         0

`endif

// ===== include/scpf_pkg.sv
// types shared by the serial control port design files
// assumes scpf_params.svh supplies the numeric constants
package scpf_pkg;

    typedef enum logic [1:0] {
        scpf_instr,
        scpf_data,
        scpf_done
    } scpf_state_t;

    typedef logic [12:0] scpf_addr_t;
    typedef logic [7:0]  scpf_byte_t;

endpackage

// ===== hw/scpf_fifo.sv
// small fifo with registered read data, valid and ready on both sides
// assumes depth is a power of two; single clock, synchronous reset
`timescale 1ns/10ps
module scpf_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready = (count < (AW+1)'(DEPTH));
    assign push     = in_valid && in_ready;
    // output stage refills whenever it is empty or being taken
    assign pop      = (count != '0) && (!out_valid || out_ready);

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + AW'(1);
            end
            if (push && !pop) begin
                count <= count + (AW+1)'(1);
            end else if (pop && !push) begin
                count <= count - (AW+1)'(1);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (pop) begin
            out_valid <= 1'b1;
            out_data  <= mem[rd_ptr];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule

// ===== dv/scpf_core_assertions.sv
// pin-level checks of the serial control port top
// assumes link pins and update pin change away from the rising clock edge
`timescale 1ns/10ps
module scpf_checker (
    input wire logic       clock,
    input wire logic       sys_rst,
    input wire logic       sclk_pin,
    input wire logic       select_n_pin,
    input wire logic       sdio_in,
    input wire logic       sdio_out,
    input wire logic       sdio_oe_n,
    input wire logic       separate_read_output,
    input wire logic       separate_read_output_oe_n,
    input wire logic       update_pin,
    input wire logic [7:0] power_down_and_enable,
    input wire logic       lsb_first_active,
    input wire logic       write_overrun
);
    logic       sclk_q;
    logic [3:0] fall_age;
    logic [3:0] rise_age;
    logic [3:0] quiet;

    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    always_ff @(posedge clock) begin
        sclk_q <= sclk_pin;
    end
    // ages saturate so a stale edge never looks recent
    always_ff @(posedge clock) begin
        if (sclk_q && !sclk_pin) fall_age <= 4'h0;
        else if (sys_rst) fall_age <= 4'hf;
        else if (fall_age != 4'hf) fall_age <= fall_age + 4'h1;
    end
    always_ff @(posedge clock) begin
        if (!sclk_q && sclk_pin) rise_age <= 4'h0;
        else if (sys_rst) rise_age <= 4'hf;
        else if (rise_age != 4'hf) rise_age <= rise_age + 4'h1;
    end
    // commits only follow link or update activity
    always_ff @(posedge clock) begin
        if (update_pin || sclk_pin) quiet <= 4'h0;
        else if (sys_rst) quiet <= 4'hf;
        else if (quiet != 4'hf) quiet <= quiet + 4'h1;
    end

    AST_RESET_STATE: assert property (disable iff (1'b0) sys_rst |=>
        power_down_and_enable == 8'h00 && !lsb_first_active && sdio_oe_n
        && separate_read_output_oe_n && !write_overrun)
        else $error("outputs not at reset values");
    AST_OE_ONE_PIN: assert property (!sdio_oe_n |-> separate_read_output_oe_n)
        else $error("both readback pins driven");
    AST_OE_IDLE: assert property (select_n_pin [*8] |-> sdio_oe_n && separate_read_output_oe_n)
        else $error("readback driven while deselected");
    AST_OE_START: assert property (($fell(sdio_oe_n) || $fell(separate_read_output_oe_n))
        |-> !select_n_pin && rise_age <= 4'h8)
        else $error("readback drive not at instruction end");
    AST_READ_LAUNCH: assert property (($changed(sdio_out) && !sdio_oe_n && !$past(sdio_oe_n))
        |-> fall_age <= 4'h7)
        else $error("readback bit moved away from a falling shift edge");
    AST_PIN_SAME: assert property (!separate_read_output_oe_n |-> separate_read_output == sdio_out)
        else $error("separate pin disagrees with readback bit");
    AST_PD_COMMIT: assert property ($changed(power_down_and_enable) |-> quiet < 4'hc)
        else $error("power-down copy changed without a commit");
    AST_LSB_COMMIT: assert property ($changed(lsb_first_active) |-> quiet < 4'hc)
        else $error("bit order changed without a commit");
    AST_OVERRUN_STICKY: assert property (write_overrun |=> write_overrun)
        else $error("overrun flag dropped");

    cover property ($fell(separate_read_output_oe_n));
    cover property ($rose(lsb_first_active));
    cover property ($changed(power_down_and_enable));
endmodule

bind scpf_core scpf_checker u_chk (
    .clock                     (clock),
    .sys_rst                   (sys_rst),
    .sclk_pin                  (sclk_pin),
    .select_n_pin              (select_n_pin),
    .sdio_in                   (sdio_in),
    .sdio_out                  (sdio_out),
    .sdio_oe_n                 (sdio_oe_n),
    .separate_read_output      (separate_read_output),
    .separate_read_output_oe_n (separate_read_output_oe_n),
    .update_pin                (update_pin),
    .power_down_and_enable     (power_down_and_enable),
    .lsb_first_active          (lsb_first_active),
    .write_overrun             (write_overrun)
);

// ===== dv/scpf_host.sv
// host model: drives the serial link and collects readback bytes
// assumes the pad merges design and host drive on the shared data pin
`timescale 1ns/10ps
module scpf_host (
    input wire logic clock,
    output logic     sclk_pin,
    output logic     select_n_pin,
    output logic     sdio_in,
    input wire logic sdio_out,
    input wire logic sdio_oe_n,
    input wire logic separate_read_output,
    input wire logic separate_read_output_oe_n
);
    logic [7:0] wbuf [0:3];
    logic [7:0] rbuf [0:3];
    logic       drv;

    // released pin toggles so a stale value never passes for data
    assign sdio_in = !sdio_oe_n ? sdio_out : drv;

    initial begin
        sclk_pin = 1'b0;
        select_n_pin = 1'b1;
        drv = 1'b0;
    end

    task automatic bit_io(input logic b, output logic r);
        drv = b;
        repeat (4) @(negedge clock);
        sclk_pin = 1'b1;
        repeat (2) @(negedge clock);
        r = !separate_read_output_oe_n ? separate_read_output : sdio_in;
        repeat (2) @(negedge clock);
        sclk_pin = 1'b0;
    endtask

    // cut above zero drops select after that many data bits
    task automatic frame(input logic rd, input logic [1:0] len, input logic [12:0] addr,
                         input int nb, input logic lsb, input int cut);
        logic [15:0] ins;
        logic        r;
        int          n;
        int          idx;
        ins = {rd, len, addr};
        n = (cut != 0) ? cut : nb * 8;
        select_n_pin = 1'b0;
        repeat (4) @(negedge clock);
        for (int i = 0; i < 16; i++) begin
            bit_io(lsb ? ins[i] : ins[15-i], r);
        end
        for (int j = 0; j < n; j++) begin
            idx = lsb ? j % 8 : 7 - j % 8;
            bit_io(rd ? ~drv : wbuf[j/8][idx], r);
            rbuf[j/8][idx] = r;
        end
        repeat (4) @(negedge clock);
        select_n_pin = 1'b1;
        drv = ~drv;
        repeat (8) @(negedge clock);
    endtask
endmodule

// ===== dv/serial_control_port_framing_bench.sv
// self-checking bench: random and corner frames through the host model
// assumes expectations come from the small register model kept here
`timescale 1ns/10ps
module serial_control_port_framing_bench
    import scpf_pkg::*;
();
    localparam logic [7:0] IDL = 8'h5a; // arbitrary value
    localparam logic [7:0] IDH = 8'hc3; // arbitrary value
    logic       clock;
    logic       sys_rst;
    logic       update_pin;
    logic       sclk_pin;
    logic       select_n_pin;
    logic       sdio_in;
    logic       sdio_out;
    logic       sdio_oe_n;
    logic       sep_out;
    logic       sep_oe_n;
    logic [7:0] pd;
    logic       lsb_act;
    logic       ovr;
    int         n_errors = 0;
    int         check_count = 0;
    int         cyc = 0;
    scpf_byte_t m_cfg = 8'h18;
    scpf_byte_t m_opt = 8'h00;
    scpf_byte_t m_pd_buf = 8'h00;
    scpf_byte_t m_pd_act = 8'h00;
    logic       m_lsb = 1'b0;

    scpf_core #(.IDENT_LOW(IDL), .IDENT_HIGH(IDH), .FIFO_DEPTH(8)) DUT (
        .clock                     (clock),
        .sys_rst                   (sys_rst),
        .sclk_pin                  (sclk_pin),
        .select_n_pin              (select_n_pin),
        .sdio_in                   (sdio_in),
        .sdio_out                  (sdio_out),
        .sdio_oe_n                 (sdio_oe_n),
        .separate_read_output      (sep_out),
        .separate_read_output_oe_n (sep_oe_n),
        .update_pin                (update_pin),
        .power_down_and_enable     (pd),
        .lsb_first_active          (lsb_act),
        .write_overrun             (ovr)
    );
    scpf_host host (
        .clock                     (clock),
        .sclk_pin                  (sclk_pin),
        .select_n_pin              (select_n_pin),
        .sdio_in                   (sdio_in),
        .sdio_out                  (sdio_out),
        .sdio_oe_n                 (sdio_oe_n),
        .separate_read_output      (sep_out),
        .separate_read_output_oe_n (sep_oe_n)
    );

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic wrap_up();
        if (n_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // a run of this length needs about 7000 cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors = n_errors + 1;
            wrap_up();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic scpf_addr_t step(scpf_addr_t a, int k, logic l);
        return l ? a + scpf_addr_t'(k) : a - scpf_addr_t'(k);
    endfunction

    function automatic scpf_byte_t exp_at(scpf_addr_t a);
        case (a)
            13'h0000: return m_opt[0] ? m_cfg : (m_cfg & 8'hbd) | (m_lsb ? 8'h42 : 8'h00);
            13'h0002: return IDL;
            13'h0003: return IDH;
            13'h0004: return m_opt;
            13'h0010: return m_opt[0] ? m_pd_buf : m_pd_act;
            default: return 8'h00;
        endcase
    endfunction

    function automatic void commit();
        m_pd_act = m_pd_buf;
        m_lsb = m_cfg[6];
    endfunction

    task automatic pulse();
        update_pin = 1'b1;
        repeat (4) @(negedge clock);
        update_pin = 1'b0;
        repeat (8) @(negedge clock);
        commit();
    endtask

    task automatic rd(input scpf_addr_t a, input logic [1:0] len);
        int nb;
        nb = (len == 2'h3) ? 4 : int'(len) + 1;
        host.frame(1'b1, len, a, nb, m_lsb, 0);
        for (int k = 0; k < nb; k++) begin
            chk(host.rbuf[k], exp_at(step(a, k, m_lsb)));
        end
    endtask

    task automatic wr(input scpf_addr_t a, input logic [1:0] len);
        int         nb;
        logic       l;
        logic       srst;
        scpf_byte_t v;
        nb = (len == 2'h3) ? 4 : int'(len) + 1;
        l = m_lsb;
        srst = 1'b0;
        host.frame(1'b0, len, a, nb, l, 0);
        for (int k = 0; k < nb; k++) begin
            v = host.wbuf[k];
            case (step(a, k, l))
                13'h0000: m_cfg = v | {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
                13'h0004: m_opt = v & 8'h01;
                13'h0005: if (v[0]) commit();
                13'h0010: m_pd_buf = v;
                default: ;
            endcase
        end
        if (m_cfg[5]) begin
            m_cfg = 8'h18;
            m_opt = 8'h00;
            m_pd_buf = 8'h00;
            m_pd_act = 8'h00;
            m_lsb = 1'b0;
        end
        repeat (8) @(negedge clock);
    endtask

    initial begin
        sys_rst = 1'b1;
        update_pin = 1'b0;
        void'($urandom(3));
        repeat (10) @(negedge clock);
        sys_rst = 1'b0;
        repeat (4) @(negedge clock);
        chk(pd, 8'h00);
        chk({4'h0, lsb_act, sdio_oe_n, sep_oe_n, ovr}, 8'h06);
        for (int l = 0; l < 4; l++) begin
            rd(13'h0004, 2'(l));
        end
        rd(13'h0000, 2'h1);
        for (int i = 0; i < 4; i++) begin
            host.wbuf[0] = 8'($urandom);
            wr(13'h0010, 2'h0);
            chk(pd, m_pd_act);
            if (i % 2 == 1) begin
                host.wbuf[0] = 8'h01;
                wr(13'h0004, 2'h0);
                rd(13'h0010, 2'h0);
                host.wbuf[0] = 8'h01;
                host.wbuf[1] = 8'h00;
                wr(13'h0005, 2'h1);
            end else begin
                pulse();
            end
            chk(pd, m_pd_act);
        end
        host.wbuf[0] = ~m_pd_buf;
        host.frame(1'b0, 2'h0, 13'h0010, 1, m_lsb, 5);
        pulse();
        chk(pd, m_pd_act);
        host.wbuf[0] = 8'h98;
        wr(13'h0000, 2'h0);
        rd(13'h0000, 2'h0);
        host.wbuf[0] = 8'h18;
        wr(13'h0000, 2'h0);
        host.wbuf[0] = 8'h58;
        wr(13'h0000, 2'h0);
        chk({7'h00, lsb_act}, 8'h00);
        rd(13'h0000, 2'h0);
        pulse();
        chk({7'h00, lsb_act}, 8'h01);
        rd(13'h0003, 2'h1);
        host.wbuf[0] = 8'h00;
        host.wbuf[1] = 8'h5a;
        host.wbuf[2] = 8'h00;
        wr(13'h1fff, 2'h2);
        rd(13'h1fff, 2'h3);
        host.wbuf[0] = 8'h78;
        wr(13'h0000, 2'h0);
        chk({7'h00, lsb_act}, 8'h00);
        rd(13'h0000, 2'h0);
        chk(pd, m_pd_act);
        host.wbuf[0] = 8'($urandom);
        host.wbuf[1] = 8'h00;
        host.wbuf[3] = 8'h00;
        wr(13'h0010, 2'h3);
        pulse();
        chk(pd, m_pd_act);
        chk({7'h00, ovr}, 8'h00);
        wrap_up();
    end
endmodule
